// [gps_pkg.sv]
// Constants shared by the eight-pin port slice: register indices, field layout,
// sense codes and reset values.
// Assumes a 32-bit AHB-Lite bus where each register index takes one aligned word.
package gps_pkg;

    localparam int unsigned GPS_PINS = 8;
    localparam int unsigned GPS_IDX_W = 6;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] GPS_IDX_DIRECTION = 6'h00;
    localparam logic [5:0] GPS_IDX_OUT_LEVEL = 6'h04;
    localparam logic [5:0] GPS_IDX_OUT_SET = 6'h05;
    localparam logic [5:0] GPS_IDX_OUT_CLEAR = 6'h06;
    localparam logic [5:0] GPS_IDX_OUT_TOGGLE = 6'h07;
    localparam logic [5:0] GPS_IDX_PIN_LEVEL = 6'h08;
    localparam logic [5:0] GPS_IDX_IRQ_FLAGS = 6'h09;
    localparam logic [5:0] GPS_IDX_IRQ_MASK = 6'h0a;
    localparam logic [5:0] GPS_IDX_PIN_CFG0 = 6'h10;
    localparam logic [5:0] GPS_IDX_PIN_CFG7 = 6'h17;

    // Pin configuration fields.
    localparam int unsigned GPS_CFG_INVERT_BIT = 7;
    localparam int unsigned GPS_CFG_PULLUP_BIT = 3;
    localparam int unsigned GPS_CFG_SENSE_LSB = 0;
    localparam logic [7:0] GPS_CFG_WMASK = 8'h8f;

    // Sense select codes.
    localparam logic [2:0] GPS_SENSE_OFF_BUF_ON = 3'h0;
    localparam logic [2:0] GPS_SENSE_ANY_EDGE = 3'h1;
    localparam logic [2:0] GPS_SENSE_RISE = 3'h2;
    localparam logic [2:0] GPS_SENSE_FALL = 3'h3;
    localparam logic [2:0] GPS_SENSE_BUF_OFF = 3'h4;
    localparam logic [2:0] GPS_SENSE_LOW_LEVEL = 3'h5;

    // Reset values.
    localparam logic [7:0] GPS_RST_BYTE = 8'h00;
    localparam logic [7:0] GPS_RST_IRQ_MASK = 8'hff;

    // AHB transfer type bit that marks NONSEQ or SEQ.
    localparam int unsigned GPS_HTRANS_ACTIVE_BIT = 1;

endpackage

// [gps_pin_sync.sv]
// Three-stage synchroniser with agreement filter for the eight port pins.
// Assumes the pins are asynchronous to clk_i.
`timescale 1ns/10ps

module gps_pin_sync
    import gps_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pins in, settled level out
    input wire logic [7:0] pin_raw_i,
    output logic [7:0] pin_settled_o
);

    typedef struct packed {
        logic [7:0] stage1;
        logic [7:0] stage2;
        logic [7:0] stage3;
        logic [7:0] settled;
    } gps_sync_s;

    gps_sync_s st_r;
    gps_sync_s st_nxt;

    // The first stage feeds only the second; a change is taken once the
    // second and third stages agree, which rejects a one-cycle glitch.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.stage1 = pin_raw_i;
        st_nxt.stage2 = st_r.stage1;
        st_nxt.stage3 = st_r.stage2;
        for (int i = 0; i < GPS_PINS; i++)
        begin
            if (st_r.stage2[i] == st_r.stage3[i])
            begin
                st_nxt.settled[i] = st_r.stage3[i];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pin_settled_o = st_r.settled;

endmodule // gps_pin_sync

// [gps_port.sv]
// Eight-pin general-purpose port slice: output level with set, clear and
// toggle strobes, sampled input level, pin interrupt flags and per-pin config.
// Assumes a single AHB-Lite master, word accesses only, and asynchronous pins.
`timescale 1ns/10ps

module gps_port
    import gps_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Pins
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    output logic [7:0] pin_weak_high_enable_o,
    // Interrupt
    output logic irq_o
);

    // All state lives in one record so that reset and the next-state copy
    // can never miss a field.
    typedef struct packed {
        logic wr_pend;
        logic [5:0] wr_idx;
        logic [7:0] rdata;
        logic [7:0] direction;
        logic [7:0] output_level;
        logic [7:0] pin_level_sample;
        logic [7:0] pin_irq_flags;
        logic [7:0] irq_mask;
        logic [63:0] pin_config;
    } gps_state_s;

    gps_state_s st_r;
    gps_state_s st_nxt;
    logic [7:0] pin_settled;

    // Pins are asynchronous, so nothing here reads them before the synchroniser.
    gps_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_raw_i(pin_i),
        .pin_settled_o(pin_settled)
    );

    function automatic logic [7:0] cfg_of(input logic [63:0] cfg, input int unsigned n);
        cfg_of = cfg[n*8 +: 8];
    endfunction

    function automatic logic [2:0] sense_of(input logic [63:0] cfg, input int unsigned n);
        logic [7:0] c;
        c = cfg_of(cfg, n);
        sense_of = c[GPS_CFG_SENSE_LSB +: 3];
    endfunction

    // The invert bit acts on both the seen input and the driven output.
    function automatic logic inv_of(input logic [63:0] cfg, input int unsigned n);
        logic [7:0] c;
        c = cfg_of(cfg, n);
        inv_of = c[GPS_CFG_INVERT_BIT];
    endfunction

    function automatic logic pull_of(input logic [63:0] cfg, input int unsigned n);
        logic [7:0] c;
        c = cfg_of(cfg, n);
        pull_of = c[GPS_CFG_PULLUP_BIT];
    endfunction

    // Only one sense code switches the input buffer off.
    function automatic logic buf_on(input logic [2:0] sense);
        buf_on = (sense != GPS_SENSE_BUF_OFF);
    endfunction

    // A new event wins over a clear in the same cycle, so no event is lost.
    function automatic logic [7:0] flags_next(input logic [7:0] old_f, input logic [7:0] clr,
                                              input logic [7:0] hit);
        flags_next = (old_f & ~clr) | hit;
    endfunction

    // Decides whether the seen level, old and new, matches the sense code.
    function automatic logic sense_hit(input logic [2:0] sense, input logic old_v,
                                       input logic new_v);
        sense_hit = 1'b0;
        case (sense)
            GPS_SENSE_ANY_EDGE:
            begin
                sense_hit = old_v ^ new_v;
            end
            GPS_SENSE_RISE:
            begin
                sense_hit = ~old_v & new_v;
            end
            GPS_SENSE_FALL:
            begin
                sense_hit = old_v & ~new_v;
            end
            GPS_SENSE_LOW_LEVEL:
            begin
                sense_hit = ~new_v;
            end
            default:
            begin
                sense_hit = 1'b0;
            end
        endcase
    endfunction

    // Every register is decoded here so that reads and writes agree.
    function automatic logic idx_mapped(input logic [5:0] idx);
        idx_mapped = 1'b0;
        if (idx == GPS_IDX_DIRECTION)
        begin
            idx_mapped = 1'b1;
        end
        else if (idx >= GPS_IDX_OUT_LEVEL && idx <= GPS_IDX_IRQ_FLAGS)
        begin
            idx_mapped = 1'b1;
        end
        else if (idx == GPS_IDX_IRQ_MASK)
        begin
            idx_mapped = 1'b1;
        end
        else if (idx >= GPS_IDX_PIN_CFG0 && idx <= GPS_IDX_PIN_CFG7)
        begin
            idx_mapped = 1'b1;
        end
    endfunction

    function automatic logic [7:0] read_mux(input gps_state_s s, input logic [5:0] idx);
        logic [2:0] n;
        n = idx[2:0];
        read_mux = GPS_RST_BYTE;
        if (idx == GPS_IDX_DIRECTION)
        begin
            read_mux = s.direction;
        end
        else if (idx >= GPS_IDX_OUT_LEVEL && idx <= GPS_IDX_OUT_TOGGLE)
        begin
            read_mux = s.output_level;
        end
        else if (idx == GPS_IDX_PIN_LEVEL)
        begin
            read_mux = s.pin_level_sample;
        end
        else if (idx == GPS_IDX_IRQ_FLAGS)
        begin
            read_mux = s.pin_irq_flags;
        end
        else if (idx == GPS_IDX_IRQ_MASK)
        begin
            read_mux = s.irq_mask;
        end
        else if (idx >= GPS_IDX_PIN_CFG0 && idx <= GPS_IDX_PIN_CFG7)
        begin
            read_mux = s.pin_config[n*8 +: 8] & GPS_CFG_WMASK;
        end
    endfunction

    // Address decode and per-pin views of the configuration.
    logic addr_ok;
    logic take;
    logic [5:0] a_idx;
    logic [7:0] wbyte;
    logic [7:0] flag_clr;
    logic [7:0] flag_hit;
    logic [7:0] seen;
    logic [7:0] inv_mask;
    logic [2:0] sense;
    logic [7:0] buf_en;
    logic [7:0] pull_req;

    // Address phase decode; only the low byte lane carries register data.
    always_comb
    begin
        a_idx = haddr_i[7:2];
        addr_ok = (haddr_i[31:8] == 24'h000000) && idx_mapped(a_idx);
        take = hsel_i && hready_i && htrans_i[GPS_HTRANS_ACTIVE_BIT];
        wbyte = hwdata_i[7:0];
    end

    // Per-pin view of the configuration, shared by sampling and the pin drive.
    always_comb
    begin
        inv_mask = 8'h00;
        buf_en = 8'h00;
        pull_req = 8'h00;
        for (int i = 0; i < GPS_PINS; i++)
        begin
            inv_mask[i] = inv_of(st_r.pin_config, i);
            buf_en[i] = buf_on(sense_of(st_r.pin_config, i));
            pull_req[i] = pull_of(st_r.pin_config, i);
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        flag_clr = 8'h00;
        flag_hit = 8'h00;
        sense = GPS_SENSE_OFF_BUF_ON;

        // Data phase of a write taken in the previous cycle.
        if (st_r.wr_pend)
        begin
            unique case (st_r.wr_idx)
                GPS_IDX_DIRECTION:
                begin
                    st_nxt.direction = wbyte;
                end
                GPS_IDX_OUT_LEVEL:
                begin
                    st_nxt.output_level = wbyte;
                end
                GPS_IDX_OUT_SET:
                begin
                    st_nxt.output_level = st_r.output_level | wbyte;
                end
                GPS_IDX_OUT_CLEAR:
                begin
                    st_nxt.output_level = st_r.output_level & ~wbyte;
                end
                GPS_IDX_OUT_TOGGLE:
                begin
                    st_nxt.output_level = st_r.output_level ^ wbyte;
                end
                GPS_IDX_PIN_LEVEL:
                begin
                    st_nxt.output_level = st_r.output_level ^ wbyte;
                end
                GPS_IDX_IRQ_FLAGS:
                begin
                    flag_clr = wbyte;
                end
                GPS_IDX_IRQ_MASK:
                begin
                    st_nxt.irq_mask = wbyte;
                end
                default:
                begin
                    st_nxt.pin_config[st_r.wr_idx[2:0]*8 +: 8] = wbyte & GPS_CFG_WMASK;
                end
            endcase
        end

        // Input sampling and sense detection use the configuration in force now.
        seen = pin_settled ^ inv_mask;
        for (int i = 0; i < GPS_PINS; i++)
        begin
            sense = sense_of(st_r.pin_config, i);
            if (buf_en[i])
            begin
                st_nxt.pin_level_sample[i] = seen[i];
                flag_hit[i] = sense_hit(sense, st_r.pin_level_sample[i], seen[i]);
            end
            else
            begin
                // A disabled buffer leaves the sample and the flag source frozen.
                st_nxt.pin_level_sample[i] = st_r.pin_level_sample[i];
            end
        end

        st_nxt.pin_irq_flags = flags_next(st_r.pin_irq_flags, flag_clr, flag_hit);

        // Address phase; read data are taken from the next state so that a read
        // right behind a write returns the written value.
        st_nxt.wr_pend = take && hwrite_i && addr_ok;
        st_nxt.wr_idx = a_idx;
        if (take && !hwrite_i)
        begin
            if (addr_ok)
            begin
                st_nxt.rdata = read_mux(st_nxt, a_idx);
            end
            else
            begin
                st_nxt.rdata = GPS_RST_BYTE;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
            // The mask resets open so that a flag reaches irq_o with no setup.
            st_r.irq_mask <= GPS_RST_IRQ_MASK;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Pins are driven straight from registered state through the inverter.
    always_comb
    begin
        pin_o = 8'h00;
        pin_weak_high_enable_o = 8'h00;
        for (int i = 0; i < GPS_PINS; i++)
        begin
            // The level matters only while the driver is enabled.
            pin_o[i] = st_r.output_level[i] ^ inv_mask[i];
            // A pull-up on a driven pin would fight the driver, so it is gated off.
            pin_weak_high_enable_o[i] = pull_req[i] & ~st_r.direction[i];
        end
    end

    assign pin_oe_o = st_r.direction;
    assign irq_o = |(st_r.pin_irq_flags & st_r.irq_mask);
    assign hrdata_o = {24'h000000, st_r.rdata};
    // The slave never stalls and never errors: zero wait states, always OKAY.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

endmodule // gps_port

// [gps_port_sva.sv]
// Checker for the port slice: register writes against pin drive and interrupt.
// Assumes word writes with address bits above 7 at zero.
`timescale 1ns/10ps
module gps_port_sva
    import gps_pkg::*;
(
    // Watched ports
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    input wire logic [7:0] pin_weak_high_enable_o,
    input wire logic irq_o
);
    // Data phase of a taken write, so each check sees its own data word.
    logic wv_r;
    logic [5:0] wi_r;
    logic [7:0] po_r;
    logic [7:0] wd;
    logic [7:0] chg;
    logic tg;
    logic fw;
    assign wd = hwdata_i[7:0];
    assign chg = pin_o ^ po_r;
    assign tg = wv_r && (wi_r == 6'h07 || wi_r == 6'h08);
    assign fw = wv_r && (wi_r == 6'h09 || wi_r == 6'h0a);
    always_ff @(posedge clk_i)
    begin
        wv_r <= rst_n_i & hsel_i & hready_i & htrans_i[1] & hwrite_i;
        wi_r <= haddr_i[7:2];
        po_r <= pin_o;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_pull_input_only: assert property ((pin_weak_high_enable_o & pin_oe_o) == 8'h00)
        else $error("pull-up on a driven pin");
    a_dir_to_drive: assert property (wv_r && wi_r == 6'h00 |=> pin_oe_o == $past(wd))
        else $error("driver enable differs from direction write");
    a_oe_quiet: assert property (pin_oe_o != $past(pin_oe_o) |-> $past(wv_r))
        else $error("driver enable changed without a write");
    a_toggle_out: assert property (tg |=> chg == $past(wd))
        else $error("toggle write gave wrong pin change");
    a_set_keeps: assert property (wv_r && wi_r == 6'h05 |=> (chg & ~$past(wd)) == 8'h00)
        else $error("set write changed a pin written with zero");
    a_clear_keeps: assert property (wv_r && wi_r == 6'h06 |=> (chg & ~$past(wd)) == 8'h00)
        else $error("clear write changed a pin written with zero");
    a_out_quiet: assert property (chg != 8'h00 |-> $past(wv_r))
        else $error("pin level changed without a write");
    a_irq_drop: assert property ($fell(irq_o) |-> $past(fw))
        else $error("interrupt dropped without a flag or mask write");
    c_toggle: cover property (tg);
    c_irq: cover property ($rose(irq_o));
    c_pull: cover property (pin_weak_high_enable_o != 8'h00);
endmodule // gps_port_sva

bind gps_port gps_port_sva chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o),
    .pin_weak_high_enable_o(pin_weak_high_enable_o));

// [gps_pad_model.sv]
// Pads and what hangs on them: port drivers, pull-up and the bench's drive.
// Assumes the bench never drives a pin that the port drives.
`timescale 1ns/10ps
module gps_pad_model
(
    // Port side
    input wire logic clk_i,
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] pu_i,
    // Bench side
    input wire logic [7:0] ext_val_i,
    input wire logic [7:0] ext_en_i,
    output logic [7:0] pad_o
);
    // A floating pin flips each cycle so a stale sample cannot pass for a level.
    logic [7:0] flip_r = 8'h55;
    always @(posedge clk_i)
    begin
        flip_r <= ~flip_r;
    end
    assign pad_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i)
        | (~oe_i & ~ext_en_i & (pu_i | flip_r));
endmodule // gps_pad_model

// [gps_port_tb.sv]
// Bench for the port slice: AHB-Lite master, pad model, one task per scenario.
// Assumes the checker binds itself to the design.
`timescale 1ns/10ps
module gps_port_tb
    import gps_pkg::*;
();
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [31:0] hrdata;
    logic hready, irq;
    logic [7:0] pin_i, pin_o, pin_oe, pull;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    always #50 clk_i = ~clk_i;
    gps_port dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .pin_weak_high_enable_o(pull),
        .irq_o(irq));
    gps_pad_model pad_u (.clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe), .pu_i(pull),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pin_i));
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic xfer(logic w, logic [5:0] idx, logic [7:0] d, output logic [31:0] r);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, idx, 2'h0};
        do @(posedge clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk_i); while (hready !== 1'b1);
        r = hrdata;
    endtask
    // Ends off the edge so that outputs are settled when looked at.
    task automatic wr(logic [5:0] idx, logic [7:0] d);
        logic [31:0] nil;
        xfer(1'b1, idx, d, nil);
        @(negedge clk_i);
    endtask
    task automatic rd(string s, logic [5:0] idx, logic [7:0] m, logic [7:0] e);
        logic [31:0] v;
        xfer(1'b0, idx, 8'h00, v);
        chk(s, {24'h0, e}, v & {24'hffffff, m});
        @(negedge clk_i);
    endtask
    task automatic settle();
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic t_regs();
        rd("mask", 6'h0a, 8'hff, 8'hff);
        rd("cfg", 6'h17, 8'hff, 8'h00);
        wr(6'h17, 8'hff);
        rd("cfg bits", 6'h17, 8'hff, 8'h8f);
        wr(6'h0b, 8'h5a);
        rd("unmapped", 6'h0b, 8'hff, 8'h00);
        wr(6'h17, 8'h00);
        $display("register test done");
    endtask
    task automatic t_out();
        wr(6'h00, 8'hff);
        chk("drive on", 32'hff, {24'h0, pin_oe});
        wr(6'h04, 8'h0f);
        wr(6'h05, 8'h30);
        rd("set", 6'h05, 8'hff, 8'h3f);
        wr(6'h06, 8'h03);
        rd("clear", 6'h06, 8'hff, 8'h3c);
        wr(6'h07, 8'hff);
        rd("toggle", 6'h07, 8'hff, 8'hc3);
        wr(6'h08, 8'h81);
        wr(6'h10, 8'h80);
        chk("pins", 32'h43, {24'h0, pin_o});
        settle();
        rd("in", 6'h08, 8'h03, 8'h02);
        wr(6'h10, 8'h00);
        wr(6'h11, 8'h08);
        chk("pull off", 32'h0, {24'h0, pull});
        wr(6'h00, 8'h00);
        chk("drive off", 32'h0, {24'h0, pin_oe});
        chk("pull on", 32'h2, {24'h0, pull});
        $display("output test done");
    endtask
    task automatic t_sense();
        logic [2:0] c;
        logic e1;
        logic e2;
        ext_en[2] <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            e1 = c == GPS_SENSE_ANY_EDGE || c == GPS_SENSE_FALL || c == GPS_SENSE_LOW_LEVEL;
            e2 = c == GPS_SENSE_ANY_EDGE || c == GPS_SENSE_RISE || c == GPS_SENSE_LOW_LEVEL;
            ext_val[2] <= 1'b1;
            wr(6'h12, {5'h0, c});
            settle();
            wr(6'h09, 8'hff);
            ext_val[2] <= 1'b0;
            settle();
            wr(6'h09, 8'hfb);
            rd("fall", 6'h09, 8'hff, {5'h0, e1, 2'h0});
            chk("irq", {31'h0, e1}, {31'h0, irq});
            wr(6'h09, 8'hff);
            ext_val[2] <= 1'b1;
            settle();
            rd("rise", 6'h09, 8'hff, {5'h0, e2, 2'h0});
            wr(6'h09, 8'hff);
            chk("irq off", 32'h0, {31'h0, irq});
        end
        wr(6'h12, 8'h01);
        wr(6'h0a, 8'h00);
        ext_val[2] <= 1'b0;
        settle();
        chk("masked", 32'h0, {31'h0, irq});
        wr(6'h0a, 8'hff);
        chk("unmasked", 32'h1, {31'h0, irq});
        wr(6'h09, 8'hff);
        $display("sense test done");
    endtask
    task automatic t_hold();
        ext_en[3] <= 1'b1;
        ext_val[3] <= 1'b1;
        settle();
        rd("in high", 6'h08, 8'h08, 8'h08);
        wr(6'h13, {5'h0, GPS_SENSE_BUF_OFF});
        ext_val[3] <= 1'b0;
        settle();
        rd("in held", 6'h08, 8'h08, 8'h08);
        wr(6'h13, 8'h00);
        settle();
        rd("in low", 6'h08, 8'h08, 8'h00);
        $display("hold test done");
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_out();
        t_sense();
        t_hold();
        wrap_up();
    end
endmodule // gps_port_tb
